// ==== logic/atu_trigger_unit.sv ====
// Acquisition trigger unit: trigger source select, trigger modes and register port.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "atu_params.svh"
module atu_trigger_unit
#(
    parameter int CNT_W = 32
)
(
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic [`ATU_ADDR_W-1:0]     reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [31:0]                     reg_rdata,
    input  wire logic [7:0]                 trig_bus,
    input  wire logic                       trig_star,
    input  wire logic [7:0]                 front_panel_function_input,
    input  wire atu_pkg::atu_sample_type    sample_in,
    output atu_pkg::atu_store_type          store_out,
    output logic                            waiting_for_trigger,
    output logic                            task_done
);
    // Whole state of this module.
    typedef struct packed {
        logic                     run;
        logic                     finite;
        atu_pkg::atu_trig_type    ttype;
        atu_pkg::atu_mode_type    tmode;
        logic                     dig_edge;
        atu_pkg::atu_cmp_type     cmode;
        logic                     ccond;
        logic [4:0]               asrc;
        logic [4:0]               dsrc;
        logic [4:0]               chan_count;
        logic [15:0]              thr_low;
        logic [15:0]              thr_high;
        logic [CNT_W-1:0]         total;
        logic [CNT_W-1:0]         pre;
        logic [CNT_W-1:0]         retrig;
        logic                     sw_trig;
        atu_pkg::atu_state_type   st;
        logic [CNT_W-1:0]         pre_cnt;
        logic [CNT_W-1:0]         cap_cnt;
        logic [CNT_W-1:0]         trig_cnt;
        logic [4:0]               slot;
        logic                     cmp_prev;
        logic [`ATU_NSRC-1:0]     sync1;
        logic [`ATU_NSRC-1:0]     sync2;
        logic [`ATU_NSRC-1:0]     sync3;
        logic [`ATU_NSRC-1:0]     stable;
        logic [31:0]              rdata;
        atu_pkg::atu_store_type   store;
    } atu_state_struct_type;

    atu_state_struct_type s_q;
    atu_state_struct_type s_d;
    logic                 cmp_out;
    logic                 src_match;
    logic                 fire;
    logic                 dig_fire;
    logic                 sel_now;
    logic                 sel_was;
    logic [`ATU_NSRC-1:0] raw_lines;

    assign raw_lines = {front_panel_function_input, trig_star, trig_bus};

    // Comparator on the chosen channel only.
    assign src_match = sample_in.valid && (sample_in.chan == s_q.asrc);

    atu_analog_cmp atu_analog_cmp_i
    (
        .mclk         (mclk),
        .resetn       (resetn),
        .sample_valid (src_match),
        .sample       (sample_in.data),
        .mode         (s_q.cmode),
        .cond         (s_q.ccond),
        .thr_low      (s_q.thr_low),
        .thr_high     (s_q.thr_high),
        .cmp_out      (cmp_out)
    );

    // Selected line now and as the filter will hold it next cycle, read from registers only
    // so the edge detector forms no loop through the next-state logic; codes past the last
    // source select nothing, so a bad source code can never fire.
    assign sel_was  = (s_q.dsrc < 5'(`ATU_NSRC)) && s_q.stable[s_q.dsrc];
    assign sel_now  = (s_q.dsrc < 5'(`ATU_NSRC))
                      && ((s_q.sync2[s_q.dsrc] == s_q.sync3[s_q.dsrc])
                          ? s_q.sync3[s_q.dsrc] : s_q.stable[s_q.dsrc]);
    // A pulse of one 20 ns width spans three cycles, enough to pass the filter.
    assign dig_fire = s_q.dig_edge ? (sel_was && !sel_now) : (!sel_was && sel_now);

    // Trigger source selection; every source but immediate gives a single-cycle event, immediate fires every cycle.
    always_comb
    begin
        case (s_q.ttype)
            atu_pkg::TRIG_IMMEDIATE: fire = 1'b1;
            atu_pkg::TRIG_SOFTWARE:  fire = s_q.sw_trig;
            atu_pkg::TRIG_ANALOG:    fire = cmp_out && !s_q.cmp_prev;
            atu_pkg::TRIG_DIGITAL:   fire = dig_fire;
            default:                 fire = 1'b0;
        endcase
    end

    // Next-state logic: register port, synchronisers and acquisition sequence.
    always_comb
    begin
        s_d             = s_q;
        s_d.sw_trig     = 1'b0;
        s_d.store.store = 1'b0;
        s_d.cmp_prev    = cmp_out;
        // Three stages; a level counts only when the second and third agree.
        s_d.sync1 = raw_lines;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < `ATU_NSRC; i++)
        begin
            if (s_q.sync2[i] == s_q.sync3[i])
                s_d.stable[i] = s_q.sync3[i];
        end
        // Register writes.
        if (reg_wr)
        begin
            case (reg_addr)
                `ATU_REG_CTRL:
                begin
                    s_d.run        = reg_wdata[0];
                    s_d.finite     = reg_wdata[1];
                    s_d.chan_count = reg_wdata[12:8];
                    if (reg_wdata[0] && !s_q.run)
                    begin
                        s_d.st       = (s_q.tmode == atu_pkg::MODE_REFERENCE)
                                       ? atu_pkg::ST_PRE : atu_pkg::ST_WAIT;
                        s_d.pre_cnt  = '0;
                        s_d.cap_cnt  = '0;
                        s_d.trig_cnt = '0;
                        s_d.slot     = '0;
                    end
                    if (!reg_wdata[0])
                        s_d.st = atu_pkg::ST_IDLE;
                end
                `ATU_REG_TRIG:
                begin
                    s_d.ttype    = atu_pkg::atu_trig_type'(reg_wdata[1:0]);
                    s_d.tmode    = atu_pkg::atu_mode_type'(reg_wdata[5:4]);
                    s_d.dig_edge = reg_wdata[8];
                    s_d.dsrc     = reg_wdata[20:16];
                    s_d.sw_trig  = reg_wdata[31];
                end
                `ATU_REG_ANALOG:
                begin
                    s_d.cmode = atu_pkg::atu_cmp_type'(reg_wdata[1:0]);
                    s_d.ccond = reg_wdata[4];
                    s_d.asrc  = reg_wdata[12:8];
                end
                `ATU_REG_THRESH:
                begin
                    s_d.thr_low  = reg_wdata[15:0];
                    s_d.thr_high = reg_wdata[31:16];
                end
                `ATU_REG_TOTAL:  s_d.total  = reg_wdata[CNT_W-1:0];
                `ATU_REG_PRE:    s_d.pre    = reg_wdata[CNT_W-1:0];
                `ATU_REG_RETRIG: s_d.retrig = reg_wdata[CNT_W-1:0];
                default:         s_d.run    = s_q.run;
            endcase
        end
        // Sequence; a slot counter walks the scan list so counts are per scan.
        if (s_q.run && !(reg_wr && reg_addr == `ATU_REG_CTRL))
        begin
            case (s_q.st)
                atu_pkg::ST_PRE:
                begin
                    if (sample_in.valid)
                    begin
                        s_d.store = '{1'b1, sample_in.chan, sample_in.data, 1'b1};
                        s_d.slot  = (s_q.slot + 5'h1 >= s_q.chan_count) ? 5'h0
                                    : s_q.slot + 5'h1;
                        if (s_q.slot + 5'h1 >= s_q.chan_count)
                            s_d.pre_cnt = s_q.pre_cnt + 1'b1;
                    end
                    if (fire && s_q.pre_cnt >= s_q.pre)
                    begin
                        s_d.st      = atu_pkg::ST_CAPTURE;
                        s_d.cap_cnt = s_q.pre;
                    end
                end
                atu_pkg::ST_WAIT:
                begin
                    if (fire)
                    begin
                        s_d.st      = atu_pkg::ST_CAPTURE;
                        s_d.cap_cnt = '0;
                        s_d.slot    = '0;
                    end
                end
                atu_pkg::ST_CAPTURE:
                begin
                    if (sample_in.valid)
                    begin
                        s_d.store = '{1'b1, sample_in.chan, sample_in.data, 1'b0};
                        s_d.slot  = (s_q.slot + 5'h1 >= s_q.chan_count) ? 5'h0
                                    : s_q.slot + 5'h1;
                        if (s_q.slot + 5'h1 >= s_q.chan_count)
                        begin
                            s_d.cap_cnt = s_q.cap_cnt + 1'b1;
                            // Finite tasks and retrigger segments end at the total.
                            if ((s_q.finite || s_q.tmode != atu_pkg::MODE_START)
                                && s_q.cap_cnt + 1'b1 >= s_q.total)
                            begin
                                s_d.trig_cnt = s_q.trig_cnt + 1'b1;
                                if (s_q.tmode == atu_pkg::MODE_RETRIGGER
                                    && (s_q.retrig == `ATU_RETRIG_FOREVER
                                        || s_q.trig_cnt + 1'b1 < s_q.retrig))
                                begin
                                    s_d.st      = atu_pkg::ST_WAIT;
                                    s_d.cap_cnt = '0;
                                end
                                else
                                    s_d.st = atu_pkg::ST_DONE;
                            end
                        end
                    end
                end
                default:
                    s_d.st = s_q.st;
            endcase
        end
        // Read data, held for exactly the cycle after the strobe.
        s_d.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `ATU_REG_CTRL:   s_d.rdata = {19'h0, s_q.chan_count, 6'h0, s_q.finite, s_q.run};
                `ATU_REG_TRIG:   s_d.rdata = {11'h0, s_q.dsrc, 7'h0, s_q.dig_edge, 2'h0,
                                              s_q.tmode, 2'h0, s_q.ttype};
                `ATU_REG_ANALOG: s_d.rdata = {19'h0, s_q.asrc, 3'h0, s_q.ccond, 2'h0, s_q.cmode};
                `ATU_REG_THRESH: s_d.rdata = {s_q.thr_high, s_q.thr_low};
                `ATU_REG_TOTAL:  s_d.rdata = 32'(s_q.total);
                `ATU_REG_PRE:    s_d.rdata = 32'(s_q.pre);
                `ATU_REG_RETRIG: s_d.rdata = 32'(s_q.retrig);
                `ATU_REG_STATUS: s_d.rdata = {27'h0, 1'b0, cmp_out,
                                              s_q.st == atu_pkg::ST_DONE,
                                              s_q.st == atu_pkg::ST_CAPTURE,
                                              s_q.st == atu_pkg::ST_WAIT
                                              || s_q.st == atu_pkg::ST_PRE};
                `ATU_REG_COUNT:  s_d.rdata = 32'(s_q.trig_cnt);
                default:         s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; pre-trigger count resets to zero.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q        <= '0;
            s_q.pre    <= CNT_W'(`ATU_PRE_RESET);
            s_q.st     <= atu_pkg::ST_IDLE;
            s_q.chan_count <= 5'h1;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata           = s_q.rdata;
    assign store_out           = s_q.store;
    assign waiting_for_trigger = s_q.run && (s_q.st == atu_pkg::ST_WAIT
                                 || s_q.st == atu_pkg::ST_PRE);
    assign task_done           = (s_q.st == atu_pkg::ST_DONE);
endmodule : atu_trigger_unit

// ==== logic/atu_params.svh ====
// Constants and timing counts for the acquisition trigger unit.
`ifndef ATU_PARAMS_SVH
`define ATU_PARAMS_SVH
`define ATU_CLK_MHZ           125
`define ATU_MIN_PULSE_NS      20
`define ATU_MIN_PULSE_CYC     ((`ATU_MIN_PULSE_NS * `ATU_CLK_MHZ + 999) / 1000)
`define ATU_ADDR_W            4
`define ATU_REG_CTRL          4'h0
`define ATU_REG_TRIG          4'h1
`define ATU_REG_ANALOG        4'h2
`define ATU_REG_THRESH        4'h3
`define ATU_REG_TOTAL         4'h4
`define ATU_REG_PRE           4'h5
`define ATU_REG_RETRIG        4'h6
`define ATU_REG_STATUS        4'h7
`define ATU_REG_COUNT         4'h8
`define ATU_PRE_RESET         32'h0000_0000
`define ATU_RETRIG_FOREVER    32'hffff_ffff
`define ATU_NSRC              17
`define ATU_SRC_STAR          5'h08
`define ATU_SRC_PANEL0        5'h09
`endif

// ==== logic/atu_pkg.sv ====
// Types of the acquisition trigger unit.
package atu_pkg;
    typedef enum logic [1:0] {TRIG_IMMEDIATE, TRIG_SOFTWARE, TRIG_ANALOG, TRIG_DIGITAL}
        atu_trig_type;
    typedef enum logic [1:0] {CMP_EDGE, CMP_HYST, CMP_WINDOW} atu_cmp_type;
    typedef enum logic [1:0] {MODE_START, MODE_REFERENCE, MODE_RETRIGGER} atu_mode_type;
    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_WAIT, ST_CAPTURE, ST_DONE} atu_state_type;
    // Analog sample from the converter.
    typedef struct packed {
        logic        valid;
        logic [4:0]  chan;
        logic [15:0] data;
    } atu_sample_type;
    // Sample handed to the storage side.
    typedef struct packed {
        logic        store;
        logic [4:0]  chan;
        logic [15:0] data;
        logic        pre;
    } atu_store_type;
endpackage : atu_pkg

// ==== logic/atu_analog_cmp.sv ====
// Analog comparator with edge, hysteresis and window modes.
`timescale 1ns/1ns
`include "atu_params.svh"
module atu_analog_cmp
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                sample_valid,
    input  wire logic signed [15:0]  sample,
    input  wire atu_pkg::atu_cmp_type mode,
    input  wire logic                cond,
    input  wire logic signed [15:0]  thr_low,
    input  wire logic signed [15:0]  thr_high,
    output logic                     cmp_out
);
    typedef struct packed {
        logic out;
        logic armed;
    } atu_cmp_state_type;

    atu_cmp_state_type s_q;
    atu_cmp_state_type s_d;

    // Thresholds are full-range signed codes so any level of the channel can be set.
    always_comb
    begin
        s_d = s_q;
        if (sample_valid)
        begin
            case (mode)
                atu_pkg::CMP_EDGE:
                begin
                    if (!cond)
                        s_d.out = (sample > thr_low);
                    else
                        s_d.out = (sample < thr_low);
                end
                atu_pkg::CMP_HYST:
                begin
                    if (!cond)
                    begin
                        if (sample < thr_low)
                        begin
                            s_d.armed = 1'b1;
                            s_d.out   = 1'b0;
                        end
                        else if (s_q.armed && sample > thr_high)
                            s_d.out = 1'b1;
                    end
                    else
                    begin
                        if (sample > thr_high)
                        begin
                            s_d.armed = 1'b1;
                            s_d.out   = 1'b0;
                        end
                        else if (s_q.armed && sample < thr_low)
                            s_d.out = 1'b1;
                    end
                end
                atu_pkg::CMP_WINDOW:
                begin
                    if (!cond)
                        s_d.out = (sample >= thr_low) && (sample <= thr_high);
                    else
                        s_d.out = (sample < thr_low) || (sample > thr_high);
                end
                default:
                    s_d.out = 1'b0;
            endcase
        end
    end

    // Comparator state register.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cmp_out = s_q.out;
endmodule : atu_analog_cmp

// ==== sim/atu_trigger_unit_monitor.sv ====
// Checker that watches the ports of the acquisition trigger unit.
`timescale 1ns/1ns
`include "atu_params.svh"
module atu_trig_monitor
#(
    parameter int CNT_W = 32
)
(
    input wire logic                    mclk,
    input wire logic                    resetn,
    input wire logic [`ATU_ADDR_W-1:0]  reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    input wire logic [7:0]              trig_bus,
    input wire logic                    trig_star,
    input wire logic [7:0]              front_panel_function_input,
    input wire atu_pkg::atu_sample_type sample_in,
    input wire atu_pkg::atu_store_type  store_out,
    input wire logic                    waiting_for_trigger,
    input wire logic                    task_done
);
    // All checks share the one clock; reset silences them.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Read data is zero except in the cycle after a read strobe.
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_status_read: assert property (reg_rd && reg_addr == `ATU_REG_STATUS |=>
        reg_rdata[0] == $past(waiting_for_trigger) && reg_rdata[2] == $past(task_done))
        else $error("status read disagrees with the pins");
    // A stored sample is the converter sample of the cycle before.
    chk_store_sample: assert property (store_out.store |-> $past(sample_in.valid) &&
        store_out.data == $past(sample_in.data) && store_out.chan == $past(sample_in.chan))
        else $error("stored sample differs from input");
    chk_done_idle: assert property (task_done |-> !waiting_for_trigger)
        else $error("waiting while done");
    chk_done_quiet: assert property (task_done && $past(task_done) |-> !store_out.store)
        else $error("store after completion");
    chk_done_holds: assert property (task_done && !(reg_wr && reg_addr == `ATU_REG_CTRL)
        |=> task_done)
        else $error("done dropped without a stop");
    chk_stop_clears: assert property (reg_wr && reg_addr == `ATU_REG_CTRL && !reg_wdata[0]
        |-> ##[1:2] !waiting_for_trigger && !task_done)
        else $error("stop did not clear status");
    // Pre-trigger samples only come while the unit is still armed.
    chk_pre_armed: assert property (store_out.store && store_out.pre
        |-> $past(waiting_for_trigger))
        else $error("pre sample after trigger");
endmodule : atu_trig_monitor

bind atu_trigger_unit atu_trig_monitor #(.CNT_W(CNT_W)) atu_trig_monitor_i (.mclk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_bus, .trig_star,
    .front_panel_function_input, .sample_in, .store_out, .waiting_for_trigger, .task_done);

// ==== sim/atu_line_model.sv ====
// Far-side model: external trigger lines and converter samples.
`timescale 1ns/1ns
module atu_line_model
(
    input  wire logic               mclk,
    output atu_pkg::atu_sample_type sample_in,
    output logic [7:0]              trig_bus,
    output logic [7:0]              front_panel_function_input,
    output logic                    trig_star
);
    // Lines idle low and no sample is offered at start.
    initial
    begin
        trig_bus = 8'h00;
        front_panel_function_input = 8'h00;
        trig_star = 1'b0;
        sample_in = '0;
    end
    // Each level is held four cycles, past the 20 ns minimum pulse width.
    task automatic line(input int src, input logic v);
        @(posedge mclk);
        if (src < 8)
            trig_bus[src] <= v;
        else if (src == 8)
            trig_star <= v;
        else
            front_panel_function_input[src-9] <= v;
        repeat (4) @(posedge mclk);
    endtask : line
    // One sample; the released bus shows inverted data so stale values never match.
    task automatic send(input logic [4:0] c, input logic [15:0] d);
        @(posedge mclk);
        sample_in <= '{valid: 1'b1, chan: c, data: d};
        @(posedge mclk);
        sample_in <= '{valid: 1'b0, chan: ~c, data: ~d};
    endtask : send
endmodule : atu_line_model

// ==== sim/atu_trigger_unit_bench.sv ====
// Self-checking bench for the acquisition trigger unit.
`timescale 1ns/1ns
`include "atu_params.svh"
module atu_trigger_unit_bench;
    logic                    mclk;
    logic                    resetn;
    logic [3:0]              reg_addr;
    logic [31:0]             reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [31:0]             reg_rdata;
    logic [31:0]             v;
    logic [7:0]              trig_bus;
    logic                    trig_star;
    logic [7:0]              front_panel_function_input;
    atu_pkg::atu_sample_type sample_in;
    atu_pkg::atu_store_type  store_out;
    logic                    waiting_for_trigger;
    logic                    task_done;
    int                      errors;
    int                      total_checks;
    int                      cycles;
    int                      pre_cnt;
    int                      post_cnt;
    logic [15:0]             seq [7] = '{16'h0, 16'h96, 16'hfa, 16'h96, 16'h0, 16'h96, 16'hfa};
    logic [4:0]              cmp_exp [6] = '{5'h1b, 5'h04, 5'h19, 5'h06, 5'h0a, 5'h15};
    // Whole status nibble after each analog step, first step in the top nibble.
    logic [27:0]             stat_exp [6] = '{28'h1aaa2aa, 28'h9111a22, 28'h11aa22a,
                                              28'h9911aa2, 28'h1a2a2a2, 28'ha2a2a2a};

    atu_trigger_unit atu_trigger_unit_i (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .trig_bus, .trig_star, .front_panel_function_input,
        .sample_in, .store_out, .waiting_for_trigger, .task_done);
    atu_line_model atu_line_model_i (.mclk, .sample_in, .trig_bus,
        .front_panel_function_input, .trig_star);

    // Free-running clock at 125 MHz.
    always #4 mclk = ~mclk;

    // Cycle limit cuts a hang short; stores are tallied by kind.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
        if (store_out.store === 1'b1 && store_out.pre === 1'b1)
            pre_cnt++;
        else if (store_out.store === 1'b1)
            post_cnt++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data is taken in the one cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        check(v, exp);
    endtask : rd
    // Stop, configure the trigger, then start with fresh tallies.
    task automatic arm(input logic [31:0] trig, input logic [31:0] ctrl);
        wr(`ATU_REG_CTRL, 32'h0);
        wr(`ATU_REG_TRIG, trig);
        wr(`ATU_REG_CTRL, ctrl);
        pre_cnt = 0;
        post_cnt = 0;
    endtask : arm
    // One software trigger followed by two scans of channels 2 then 0.
    task automatic shot();
        wr(`ATU_REG_TRIG, 32'h8000_0021);
        cyc(2);
        repeat (2)
        begin
            atu_line_model_i.send(5'h2, 16'h0222);
            atu_line_model_i.send(5'h0, 16'h0111);
        end
        cyc(3);
    endtask : shot
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Main sequence of tests.
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {errors, total_checks, cycles, pre_cnt, post_cnt} = '0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rd(`ATU_REG_CTRL, 32'h0000_0100);
        rd(`ATU_REG_PRE, `ATU_PRE_RESET);
        rd(4'hf, 32'h0);
        $display("test reset done");
        wr(`ATU_REG_TOTAL, 32'h3);
        arm(32'h0, 32'h103);
        cyc(2);
        check({31'h0, waiting_for_trigger}, 32'h0);
        repeat (3) atu_line_model_i.send(5'h0, 16'h0123);
        cyc(3);
        check(post_cnt, 3);
        check({31'h0, task_done}, 32'h1);
        $display("test immediate done");
        arm(32'h1, 32'h103);
        repeat (2) atu_line_model_i.send(5'h0, 16'h0456);
        cyc(3);
        check(post_cnt, 0);
        rd(`ATU_REG_STATUS, 32'h9);
        wr(`ATU_REG_TRIG, 32'h8000_0001);
        cyc(2);
        check({31'h0, waiting_for_trigger}, 32'h0);
        $display("test software done");
        for (int s = 0; s < `ATU_NSRC; s++)
        begin
            arm({11'h0, s[4:0], 16'h0003}, 32'h101);
            cyc(2);
            check({31'h0, waiting_for_trigger}, 32'h1);
            atu_line_model_i.line(s, 1'b1);
            cyc(4);
            check({31'h0, waiting_for_trigger}, 32'h0);
            atu_line_model_i.line(s, 1'b0);
        end
        arm(32'h0000_0103, 32'h101);
        atu_line_model_i.line(0, 1'b1);
        cyc(4);
        check({31'h0, waiting_for_trigger}, 32'h1);
        atu_line_model_i.line(0, 1'b0);
        cyc(4);
        check({31'h0, waiting_for_trigger}, 32'h0);
        $display("test digital done");
        wr(`ATU_REG_THRESH, 32'h00c8_0064);
        for (int k = 0; k < 6; k++)
        begin
            wr(`ATU_REG_ANALOG, {19'h0, 5'h3, 3'h0, k[0], 2'h0, k[2:1]});
            arm(32'h2, 32'h101);
            for (int i = 0; i < 7; i++)
            begin
                atu_line_model_i.send(5'h3, seq[i]);
                rd(`ATU_REG_STATUS, {28'h0, stat_exp[k][27-4*i -: 4]});
                if (i > 1)
                    check({28'h0, v[3], 3'h0}, {28'h0, cmp_exp[k][6-i], 3'h0});
            end
        end
        $display("test analog done");
        wr(`ATU_REG_PRE, 32'h2);
        wr(`ATU_REG_TOTAL, 32'h5);
        arm(32'h11, 32'h103);
        atu_line_model_i.send(5'h0, 16'h0aaa);
        wr(`ATU_REG_TRIG, 32'h8000_0011);
        cyc(2);
        check({31'h0, waiting_for_trigger}, 32'h1);
        atu_line_model_i.send(5'h0, 16'h0bbb);
        wr(`ATU_REG_TRIG, 32'h8000_0011);
        cyc(2);
        check({31'h0, waiting_for_trigger}, 32'h0);
        repeat (3) atu_line_model_i.send(5'h0, 16'h0ccc);
        cyc(3);
        check(pre_cnt, 2);
        check(post_cnt, 3);
        check({31'h0, task_done}, 32'h1);
        $display("test reference done");
        wr(`ATU_REG_TOTAL, 32'h2);
        wr(`ATU_REG_RETRIG, 32'h2);
        arm(32'h21, 32'h203);
        repeat (2) shot();
        check(post_cnt, 8);
        check({31'h0, task_done}, 32'h1);
        rd(`ATU_REG_COUNT, 32'h2);
        wr(`ATU_REG_RETRIG, `ATU_RETRIG_FOREVER);
        arm(32'h21, 32'h203);
        repeat (3) shot();
        check({31'h0, task_done}, 32'h0);
        check({31'h0, waiting_for_trigger}, 32'h1);
        rd(`ATU_REG_COUNT, 32'h3);
        wr(`ATU_REG_CTRL, 32'h0);
        cyc(2);
        check({31'h0, waiting_for_trigger}, 32'h0);
        $display("test retrigger done");
        results();
    end
endmodule : atu_trigger_unit_bench
